// ### logic/alu_pkg.sv
// package with opcodes, widths and reset values for the arithmetic/logic/bit slice
package alu_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int BIT_W = 3;
  localparam int NIBBLE_W = 4;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic NIBBLE_RESET = 1'b0;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic WE_RESET = 1'b0;
  localparam logic [5:0] WADDR_RESET = 6'h00;
  localparam logic [7:0] WDATA_RESET = 8'h00;
  localparam int EXEC_CYCLES = 1;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD_IMM_WITH_CARRY,
    OP_ADD_IMM,
    OP_AND_WITH_REG,
    OP_AND_WITH_IMM,
    OP_BIT_CLEAR,
    OP_BIT_SET
  } alu_op_t;
endpackage

// ### logic/nibble_adder.sv
// adder that reports the result, nibble overflow and carry out
`timescale 1ns/1ps
module nibble_adder #(
  parameter int WIDTH = 8,
  parameter int LOW_W = 4
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  output logic [WIDTH-1:0] sum,
  output logic low_carry,
  output logic carry_out
);
  logic [LOW_W:0] low_sum;
  logic [WIDTH:0] full_sum;

  // low nibble sum exposes the digit carry, full sum the carry
  always_comb begin
    low_sum = {1'b0, a[LOW_W-1:0]} + {1'b0, b[LOW_W-1:0]} + {{LOW_W{1'b0}}, cin};
    full_sum = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
    sum = full_sum[WIDTH-1:0];
    low_carry = low_sum[LOW_W];
    carry_out = full_sum[WIDTH];
  end
endmodule

// ### logic/alu_datapath.sv
// single-cycle datapath for add-immediate, and, and bit set/clear operations
`timescale 1ns/1ps
// Overview of operation
// - add_imm_with_carry adds working register, immediate and carry into the working register, updates Z/DC/C, one cycle.
// - add_imm adds working register and immediate ignoring carry into the working register, updates Z/DC/C, one cycle.
// - and_with_reg ands the working register with register 0..63, dest bit 0 writes working register, 1 writes back; only Z.
// - and_with_imm ands the working register with the immediate into the working register, only Z, one cycle.
// - bit_clear_op forces the chosen bit of the addressed register to zero, leaving other bits and flags, one cycle.
// - bit_set_op forces the chosen bit of the addressed register to one, leaving other bits and flags, one cycle.
// - an addition sets carry when the 8-bit sum carries out and clears it otherwise.
module alu_datapath #(
  parameter int DATA_W = alu_pkg::DATA_W,
  parameter int ADDR_W = alu_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire alu_pkg::alu_op_t op,
  input wire logic [alu_pkg::DATA_W-1:0] imm,
  input wire logic [alu_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [alu_pkg::BIT_W-1:0] bit_sel,
  input wire logic dest_sel,
  input wire logic [alu_pkg::DATA_W-1:0] reg_rdata,
  output logic [alu_pkg::ADDR_W-1:0] reg_raddr,
  output logic reg_we,
  output logic [alu_pkg::ADDR_W-1:0] reg_waddr,
  output logic [alu_pkg::DATA_W-1:0] reg_wdata,
  output logic [alu_pkg::DATA_W-1:0] working_register,
  output logic zero_flag,
  output logic nibble_overflow_bit,
  output logic carry_flag
);
  import alu_pkg::*;

  logic [DATA_W-1:0] wreg_reg, wreg_next;
  logic zero_reg, zero_next;
  logic nibble_reg, nibble_next;
  logic carry_reg, carry_next;
  logic we_reg, we_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic add_cin;
  logic [DATA_W-1:0] add_sum;
  logic add_low_carry;
  logic add_carry;
  logic [DATA_W-1:0] and_b;
  logic [DATA_W-1:0] and_res;
  logic [DATA_W-1:0] bit_mask;

  // one-hot mask for the selected bit position
  function automatic logic [DATA_W-1:0] bit_onehot(input logic [BIT_W-1:0] pos);
    bit_onehot = {{(DATA_W-1){1'b0}}, 1'b1} << pos;
  endfunction

  // zero test shared by adds and ands
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == '0);
  endfunction

  // true for either add flavour, used by the carry and nibble overflow next-state group
  function automatic logic is_add(input alu_op_t o);
    is_add = (o == OP_ADD_IMM_WITH_CARRY) || (o == OP_ADD_IMM);
  endfunction

  // register file read port follows the instruction address
  assign reg_raddr = reg_addr;

  // carry feeds in only for the with-carry add
  assign add_cin = (op == OP_ADD_IMM_WITH_CARRY) ? carry_reg : 1'b0;

  nibble_adder #(
    .WIDTH(DATA_W),
    .LOW_W(NIBBLE_W)
  ) u_adder (
    .a(wreg_reg),
    .b(imm),
    .cin(add_cin),
    .sum(add_sum),
    .low_carry(add_low_carry),
    .carry_out(add_carry)
  );

  // operand selection for the and operations
  assign and_b = (op == OP_AND_WITH_REG) ? reg_rdata : imm;
  assign and_res = wreg_reg & and_b;
  assign bit_mask = bit_onehot(bit_sel);

  // every group below settles on the same edge, so each instruction takes one cycle
  // and a following instruction sees the updated working register and flags at once

  // working register takes add results and and results except and_with_reg with dest_sel 1, bit ops leave it alone
  always_comb begin
    wreg_next = wreg_reg;
    case (op)
      OP_ADD_IMM_WITH_CARRY, OP_ADD_IMM: begin
        wreg_next = add_sum;
      end
      OP_AND_WITH_REG: begin
        if (!dest_sel) begin
          wreg_next = and_res;
        end
      end
      OP_AND_WITH_IMM: begin
        wreg_next = and_res;
      end
      OP_BIT_CLEAR, OP_BIT_SET: begin
        wreg_next = wreg_reg;
      end
      default: begin
        wreg_next = wreg_reg;
      end
    endcase
  end

  // working register storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wreg_reg <= WREG_RESET;
    end else begin
      wreg_reg <= wreg_next;
    end
  end

  // zero flag follows adds and ands, bit ops keep it
  always_comb begin
    zero_next = zero_reg;
    case (op)
      OP_ADD_IMM_WITH_CARRY, OP_ADD_IMM: begin
        zero_next = is_zero(add_sum);
      end
      OP_AND_WITH_REG, OP_AND_WITH_IMM: begin
        zero_next = is_zero(and_res);
      end
      default: begin
        zero_next = zero_reg;
      end
    endcase
  end

  // zero flag storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zero_reg <= ZERO_RESET;
    end else begin
      zero_reg <= zero_next;
    end
  end

  // carry and nibble overflow change only on adds, ands keep them
  always_comb begin
    nibble_next = nibble_reg;
    carry_next = carry_reg;
    if (is_add(op)) begin
      nibble_next = add_low_carry;
      carry_next = add_carry;
    end
  end

  // carry and nibble overflow storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nibble_reg <= NIBBLE_RESET;
      carry_reg <= CARRY_RESET;
    end else begin
      nibble_reg <= nibble_next;
      carry_reg <= carry_next;
    end
  end

  // register write-back for and-to-register and bit set/clear
  always_comb begin
    we_next = 1'b0;
    waddr_next = reg_addr;
    wdata_next = wdata_reg;
    case (op)
      OP_AND_WITH_REG: begin
        if (dest_sel) begin
          we_next = 1'b1;
          wdata_next = and_res;
        end
      end
      OP_BIT_CLEAR: begin
        we_next = 1'b1;
        wdata_next = reg_rdata & ~bit_mask;
      end
      OP_BIT_SET: begin
        we_next = 1'b1;
        wdata_next = reg_rdata | bit_mask;
      end
      default: begin
        we_next = 1'b0;
      end
    endcase
  end

  // write port storage, strobe lasts one cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      we_reg <= WE_RESET;
      waddr_reg <= WADDR_RESET;
      wdata_reg <= WDATA_RESET;
    end else begin
      we_reg <= we_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  // outputs straight from flip-flops
  assign working_register = wreg_reg;
  assign zero_flag = zero_reg;
  assign nibble_overflow_bit = nibble_reg;
  assign carry_flag = carry_reg;
  assign reg_we = we_reg;
  assign reg_waddr = waddr_reg;
  assign reg_wdata = wdata_reg;
endmodule

// ### dv/alu_checker.sv
// checker for the datapath slice
`timescale 1ns/1ps
module alu_checker import alu_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire alu_op_t op,
  input wire logic [7:0] imm,
  input wire logic [5:0] reg_addr,
  input wire logic [2:0] bit_sel,
  input wire logic dest_sel,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_we,
  input wire logic [5:0] reg_waddr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] working_register,
  input wire logic zero_flag,
  input wire logic nibble_overflow_bit,
  input wire logic carry_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // low-nibble sum with any carry fed in
  logic [4:0] lo;
  assign lo = working_register[3:0] + imm[3:0] + (op == OP_ADD_IMM_WITH_CARRY && carry_flag);
  sequence add_op;
    op == OP_ADD_IMM || op == OP_ADD_IMM_WITH_CARRY;
  endsequence
  adc_sum_a: assert property (op == OP_ADD_IMM_WITH_CARRY |=>
    {carry_flag, working_register} == $past(working_register) + $past(imm) + $past(carry_flag)) else $error("adc");
  add_sum_a: assert property (op == OP_ADD_IMM |=>
    {carry_flag, working_register} == $past(working_register) + $past(imm)) else $error("add");
  and_reg_a: assert property (op == OP_AND_WITH_REG |=>
    reg_we == $past(dest_sel) && zero_flag == (($past(working_register) & $past(reg_rdata)) == 8'h00)) else $error("andr");
  and_imm_a: assert property (op == OP_AND_WITH_IMM |=>
    working_register == ($past(working_register) & $past(imm)) && $stable({carry_flag, nibble_overflow_bit}))
    else $error("andi");
  bit_clr_a: assert property (op == OP_BIT_CLEAR |=>
    reg_we && reg_wdata == ($past(reg_rdata) & ~(8'h01 << $past(bit_sel))) && $stable(zero_flag)) else $error("bclr");
  bit_set_a: assert property (op == OP_BIT_SET |=>
    reg_we && reg_waddr == $past(reg_addr) && reg_wdata == ($past(reg_rdata) | (8'h01 << $past(bit_sel))))
    else $error("bset");
  nib_carry_a: assert property (add_op |=> nibble_overflow_bit == $past(lo[4])) else $error("dc");
  zero_add_a: assert property (add_op |=> zero_flag == (working_register == 8'h00)) else $error("z");
endmodule
bind alu_datapath alu_checker u_chk(.*);

// ### dv/test_alu_datapath.sv
// bench for the datapath slice
`timescale 1ns/1ps
module test_alu_datapath;
  import alu_pkg::*;
  logic clk_sys = 0, nrst = 0, dest_sel = 0, reg_we, zero_flag, nibble_overflow_bit, carry_flag;
  alu_op_t op = OP_NONE;
  logic [7:0] imm = 8'h00, reg_rdata = 8'h00, reg_wdata, working_register;
  logic [5:0] reg_addr = 6'h3F, reg_raddr, reg_waddr;
  logic [2:0] bit_sel = 3'h0;
  int bad_count = 0, n_checks = 0, cyc = 0;
  alu_datapath dut(.*);
  always #5 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 200) begin
      bad_count++;
      wrap_up();
    end
  end
  // one op, then judge write port, flags and working register
  task step(alu_op_t o, logic [7:0] i, r, logic [2:0] b, logic d, logic [25:0] e);
    logic [25:0] g;
    @(negedge clk_sys);
    op = o;
    imm = i;
    reg_rdata = r;
    bit_sel = b;
    dest_sel = d;
    @(negedge clk_sys);
    op = OP_NONE;
    g = {reg_we, reg_we ? {reg_waddr, reg_wdata} : 14'h0000, carry_flag, nibble_overflow_bit, zero_flag, working_register};
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
    n_checks++;
    if (reg_raddr !== reg_addr) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_raddr, reg_addr);
    end
  endtask
  task t_add;
    step(OP_ADD_IMM, 8'h12, 8'h00, 3'h0, 1'b0, 26'h012);
    step(OP_ADD_IMM, 8'hEE, 8'h00, 3'h0, 1'b0, 26'h700);
    step(OP_ADD_IMM_WITH_CARRY, 8'h12, 8'h00, 3'h0, 1'b0, 26'h013);
    step(OP_ADD_IMM, 8'hEE, 8'h00, 3'h0, 1'b0, 26'h601);
    step(OP_ADD_IMM, 8'h0F, 8'h00, 3'h0, 1'b0, 26'h210);
    $display("t_add done");
  endtask
  task t_and;
    step(OP_AND_WITH_REG, 8'h00, 8'hAF, 3'h0, 1'b1, {1'b1, 6'h3F, 8'h00, 11'h310});
    step(OP_AND_WITH_REG, 8'h00, 8'h30, 3'h0, 1'b0, 26'h210);
    step(OP_AND_WITH_IMM, 8'hEF, 8'h00, 3'h0, 1'b0, 26'h300);
    $display("t_and done");
  endtask
  task t_bit;
    step(OP_BIT_SET, 8'h00, 8'h5A, 3'h2, 1'b0, {1'b1, 6'h3F, 8'h5E, 11'h300});
    step(OP_BIT_SET, 8'h00, 8'h00, 3'h7, 1'b0, {1'b1, 6'h3F, 8'h80, 11'h300});
    reg_addr = 6'h05;
    step(OP_BIT_CLEAR, 8'h00, 8'h5A, 3'h3, 1'b0, {1'b1, 6'h05, 8'h52, 11'h300});
    $display("t_bit done");
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    nrst = 1;
    t_add();
    t_and();
    t_bit();
    wrap_up();
  end
endmodule
